// ### core/nfc_irq_core.sv
// Interrupt masks, clear-on-read event status, collision avoidance guard and AXI4-Lite slave
`timescale 1ns/1ps
`include "nfc_irq_consts.svh"
// What this block does
// RL1: Masks clear at power-up and set-default
// RL2: Main mask holds six source bits
// RL3: Timer/field mask holds eight source bits
// RL4: Error/wake-up mask holds eight source bits
// RL5: Stable started oscillator sets main bit 7
// RL6: Receive with FIFO nearly full sets bit 6
// RL7: Transmit with FIFO nearly empty sets bit 6
// RL8: Main status flags receive, transmit, collision
// RL9: Main bits 1,0 summarise secondary registers
// RL10: Main read clears all but summary bits
// RL11: Timer/field status follows its mask order
// RL12: Field during avoidance sets collision bit
// RL13: No field: field on, guard-time bit later
// RL14: Reading timer/field status clears it
// RL15: Interrupt while any unmasked status set
// RL16: Error/wake-up status feeds summary bit 0
module nfc_irq_core
   import nfc_irq_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic osc_en,
   input wire logic osc_stable,
   input wire logic rx_active,
   input wire logic tx_active,
   input wire logic fifo_near_full,
   input wire logic fifo_near_empty,
   input wire logic rx_start,
   input wire logic rx_end,
   input wire logic tx_end,
   input wire logic bit_col,
   input wire logic cmd_done,
   input wire logic nrt_expire,
   input wire logic gpt_expire,
   input wire logic field_rise,
   input wire logic field_fall,
   input wire logic bitrate_found,
   input wire logic ca_start,
   input wire logic ca_end,
   input wire logic ext_field,
   input wire logic [7:0] err_evt,
   output logic field_on,
   output logic irq
);
   localparam int GUARD_CYC = (`GUARD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int GW = $clog2(GUARD_CYC + 1);

   logic aw_held_r, w_held_r, bvalid_r, rvalid_r, irq_r, field_on_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [7:0] mask_main_r, mask_tim_r, mask_err_r;
   logic [7:2] main_ev_r;
   logic [7:0] tim_r, err_r, main_view, tim_set;
   logic [7:2] main_set;
   logic osc_prev_r, lvl_prev_r, osc_ok, lvl_cond;
   logic wr_go, rd_go, set_default, pending, cac_set, cat_set;
   reg_sel_t sel_w, sel_r;
   ca_state_t ca_st_r;
   logic [GW-1:0] guard_cnt_r;

   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
      if (a[ADDR_W-1:2] == `IDX_MASK_MAIN) return SEL_MMAIN;
      else if (a[ADDR_W-1:2] == `IDX_MASK_TIM) return SEL_MTIM;
      else if (a[ADDR_W-1:2] == `IDX_MASK_ERR) return SEL_MERR;
      else if (a[ADDR_W-1:2] == `IDX_STAT_MAIN) return SEL_SMAIN;
      else if (a[ADDR_W-1:2] == `IDX_STAT_TIM) return SEL_STIM;
      else if (a[ADDR_W-1:2] == `IDX_STAT_ERR) return SEL_SERR;
      else if (a[ADDR_W-1:2] == `IDX_COMMAND) return SEL_CMD;
      else return SEL_NONE;
   endfunction

   // Write address and data are latched separately, so either may come first
   assign awready = !aw_held_r && !bvalid_r;
   assign wready = !w_held_r && !bvalid_r;
   assign arready = !rvalid_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign irq = irq_r;
   assign field_on = field_on_r;
   assign sel_w = decode(awaddr_r);
   assign sel_r = decode(araddr);
   assign wr_go = aw_held_r && w_held_r && !bvalid_r;
   assign rd_go = arvalid && arready;
   assign set_default = wr_go && wstrb_r[0] && sel_w == SEL_CMD && wdata_r[`CMD_SET_DEFAULT_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= awaddr;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= (sel_w == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Masks; unused main bits 1 and 0 are forced to zero on every write and read as zero
   always_ff @(posedge aclk) begin
      if (!aresetn || set_default) begin // [RL1]
         mask_main_r <= `MASK_RESET;
         mask_tim_r <= `MASK_RESET;
         mask_err_r <= `MASK_RESET;
      end else if (wr_go && wstrb_r[0]) begin
         if (sel_w == SEL_MMAIN) mask_main_r <= wdata_r[7:0] & `MASK_MAIN_USED; // [RL2]
         if (sel_w == SEL_MTIM) mask_tim_r <= wdata_r[7:0]; // [RL3]
         if (sel_w == SEL_MERR) mask_err_r <= wdata_r[7:0]; // [RL4]
      end
   end

   // Oscillator and FIFO-level events are taken on rising conditions so a held level flags once
   assign osc_ok = osc_en && osc_stable;
   assign lvl_cond = (rx_active && fifo_near_full) || (tx_active && fifo_near_empty); // [RL6] [RL7]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_prev_r <= 1'b0;
         lvl_prev_r <= 1'b0;
      end else begin
         osc_prev_r <= osc_ok;
         lvl_prev_r <= lvl_cond;
      end
   end

   assign main_set = {osc_ok && !osc_prev_r, lvl_cond && !lvl_prev_r, // [RL5]
      rx_start, rx_end, tx_end, bit_col}; // [RL8]
   assign tim_set = {cmd_done, nrt_expire, gpt_expire, field_rise, field_fall, cac_set, cat_set,
      bitrate_found}; // [RL11]
   assign main_view = {main_ev_r, |tim_r, |err_r}; // [RL9] [RL16]

   // Clear-on-read: an event arriving in the reading cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn || set_default) begin
         main_ev_r <= 6'h00;
         tim_r <= 8'h00;
         err_r <= 8'h00;
      end else begin
         main_ev_r <= ((rd_go && sel_r == SEL_SMAIN) ? 6'h00 : main_ev_r) | main_set; // [RL10]
         tim_r <= ((rd_go && sel_r == SEL_STIM) ? 8'h00 : tim_r) | tim_set; // [RL14]
         err_r <= ((rd_go && sel_r == SEL_SERR) ? 8'h00 : err_r) | err_evt; // [RL16]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rresp_r <= (sel_r == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
         unique case (sel_r)
            SEL_MMAIN: rdata_r <= {24'h00_0000, mask_main_r};
            SEL_MTIM: rdata_r <= {24'h00_0000, mask_tim_r};
            SEL_MERR: rdata_r <= {24'h00_0000, mask_err_r};
            SEL_SMAIN: rdata_r <= {24'h00_0000, main_view};
            SEL_STIM: rdata_r <= {24'h00_0000, tim_r};
            SEL_SERR: rdata_r <= {24'h00_0000, err_r};
            SEL_CMD, SEL_NONE: rdata_r <= 32'h0000_0000;
         endcase
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Collision avoidance: listen for a foreign field, else raise ours and wait out the guard time
   assign cac_set = ca_st_r == CA_LISTEN && ext_field; // [RL12]
   assign cat_set = ca_st_r == CA_GUARD && guard_cnt_r == GW'(GUARD_CYC - 1); // [RL13]
   always_ff @(posedge aclk) begin
      if (!aresetn || set_default) begin
         ca_st_r <= CA_IDLE;
         field_on_r <= 1'b0;
         guard_cnt_r <= '0;
      end else begin
         unique case (ca_st_r)
            CA_IDLE: begin
               if (ca_start) begin
                  ca_st_r <= CA_LISTEN;
                  field_on_r <= 1'b0;
               end
            end
            CA_LISTEN: begin
               if (ext_field) begin
                  ca_st_r <= CA_IDLE;
               end else if (ca_end) begin
                  ca_st_r <= CA_GUARD; // [RL13]
                  field_on_r <= 1'b1;
                  guard_cnt_r <= '0;
               end
            end
            CA_GUARD: begin
               if (cat_set) ca_st_r <= CA_IDLE;
               else guard_cnt_r <= guard_cnt_r + GW'(1);
            end
         endcase
      end
   end

   // Summary bits are not masked themselves; their sources are
   assign pending = |(main_ev_r & ~mask_main_r[7:2]) || |(tim_r & ~mask_tim_r) || |(err_r & ~mask_err_r);
   always_ff @(posedge aclk) begin
      if (!aresetn) irq_r <= 1'b0;
      else irq_r <= pending; // [RL15]
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   mask_default_clear_a: assert property (set_default // [RL1]
      |=> mask_main_r == 8'h00 && mask_tim_r == 8'h00 && mask_err_r == 8'h00)
      else $error("masks not cleared by set default");
   main_mask_write_a: assert property (wr_go && wstrb_r[0] && sel_w == SEL_MMAIN // [RL2]
      |=> mask_main_r == ($past(wdata_r[7:0]) & 8'hFC))
      else $error("main mask write lost");
   tim_mask_write_a: assert property (wr_go && wstrb_r[0] && sel_w == SEL_MTIM // [RL3]
      |=> mask_tim_r == $past(wdata_r[7:0]))
      else $error("timer mask write lost");
   err_mask_write_a: assert property (wr_go && wstrb_r[0] && sel_w == SEL_MERR // [RL4]
      |=> mask_err_r == $past(wdata_r[7:0]))
      else $error("error mask write lost");
   osc_stable_flag_a: assert property ($rose(osc_en && osc_stable) && !set_default // [RL5]
      |=> main_view[`MAIN_OSC_BIT])
      else $error("oscillator flag missing");
   rx_level_flag_a: assert property ($rose(rx_active && fifo_near_full) && !lvl_prev_r && !set_default // [RL6]
      |=> main_view[`MAIN_LEVEL_BIT])
      else $error("receive level flag missing");
   tx_level_flag_a: assert property ($rose(tx_active && fifo_near_empty) && !lvl_prev_r && !set_default // [RL7]
      |=> main_view[`MAIN_LEVEL_BIT])
      else $error("transmit level flag missing");
   // The interrupt follows one cycle after the flag, judged against the mask of the flag's cycle
   rx_end_flag_a: assert property (rx_end && !set_default // [RL8]
      |=> main_view[`MAIN_RXE_BIT] ##1 (irq_r || $past(mask_main_r[`MAIN_RXE_BIT])))
      else $error("receive end flag missing");
   summary_kept_a: assert property (rd_go && sel_r == SEL_SMAIN && tim_r != 8'h00 && !set_default // [RL9]
      |=> main_view[`MAIN_TIM_BIT] && main_view[7:2] == $past(main_set))
      else $error("summary lost on main read");
   main_read_clear_a: assert property (rd_go && sel_r == SEL_SMAIN && main_set == 6'h00 // [RL10]
      |=> main_ev_r == 6'h00)
      else $error("main status not cleared");
   tim_order_a: assert property (cmd_done && !set_default |=> tim_r[`TIM_DCT_BIT]) // [RL11]
      else $error("direct command flag missing");
   ca_collision_a: assert property (ca_st_r == CA_LISTEN && ext_field && !set_default // [RL12]
      |=> tim_r[`TIM_CAC_BIT] && !field_on_r)
      else $error("avoidance collision flag missing");
   // A guard flag still unread from an earlier pass would hide an early one, so start from a clear bit
   guard_time_a: assert property (disable iff (!aresetn || set_default) // [RL13]
      ca_st_r == CA_LISTEN && !ext_field && ca_end && !tim_r[`TIM_CAT_BIT]
      |=> field_on_r && !tim_r[`TIM_CAT_BIT] ##[1:GUARD_CYC] tim_r[`TIM_CAT_BIT])
      else $error("guard time flag not raised");
   tim_read_clear_a: assert property (rd_go && sel_r == SEL_STIM && tim_set == 8'h00 && err_r == 8'h00 // [RL14] [RL9]
      |=> tim_r == 8'h00 && !main_view[`MAIN_TIM_BIT])
      else $error("timer status not cleared");
   unmasked_irq_a: assert property (err_evt[`ERR_WT_BIT] && !mask_err_r[`ERR_WT_BIT] // [RL15]
      && !wr_go && !set_default |-> ##2 irq_r)
      else $error("unmasked event gave no interrupt");
   masked_quiet_a: assert property ((mask_main_r == 8'hFC && mask_tim_r == 8'hFF && mask_err_r == 8'hFF)[*2] // [RL15]
      |-> !irq_r)
      else $error("masked event raised interrupt");
   err_summary_a: assert property (err_evt[`ERR_CRC_BIT] && !set_default // [RL16]
      |=> err_r[`ERR_CRC_BIT] && main_view[`MAIN_ERR_BIT])
      else $error("error flag or summary missing");

   main_read_cov: cover property (rd_go && sel_r == SEL_SMAIN && main_ev_r != 6'h00);
   guard_done_cov: cover property (cat_set);
   irq_rise_cov: cover property ($rose(irq_r));
   set_default_cov: cover property (set_default && mask_tim_r != 8'h00);
endmodule

// ### inc/nfc_irq_consts.svh
// Register indices, field positions, reset values and nanosecond timing values of the interrupt block
`ifndef NFC_IRQ_CONSTS_SVH
`define NFC_IRQ_CONSTS_SVH
`define IDX_MASK_MAIN 6'h14
`define IDX_MASK_TIM 6'h15
`define IDX_MASK_ERR 6'h16
`define IDX_STAT_MAIN 6'h17
`define IDX_STAT_TIM 6'h18
`define IDX_STAT_ERR 6'h19
`define IDX_COMMAND 6'h20
`define CMD_SET_DEFAULT_BIT 0
`define MASK_RESET 8'h00
`define MASK_MAIN_USED 8'hFC
`define MAIN_OSC_BIT 7
`define MAIN_LEVEL_BIT 6
`define MAIN_RXS_BIT 5
`define MAIN_RXE_BIT 4
`define MAIN_TXE_BIT 3
`define MAIN_COL_BIT 2
`define MAIN_TIM_BIT 1
`define MAIN_ERR_BIT 0
`define TIM_DCT_BIT 7
`define TIM_CAC_BIT 2
`define TIM_CAT_BIT 1
`define ERR_CRC_BIT 7
`define ERR_WT_BIT 3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define CLK_PERIOD_NS 5
`define GUARD_TIME_NS 5000
`endif

// ### inc/nfc_irq_pkg.sv
// Types shared by the interrupt mask and status block
package nfc_irq_pkg;
   typedef enum logic [2:0] {SEL_MMAIN, SEL_MTIM, SEL_MERR, SEL_SMAIN, SEL_STIM, SEL_SERR, SEL_CMD,
      SEL_NONE} reg_sel_t;
   typedef enum logic [1:0] {CA_IDLE, CA_LISTEN, CA_GUARD} ca_state_t;
endpackage

// ### sim/host_bus_model.sv
// Host-side AXI4-Lite master that the bench uses to reach the interrupt registers
`timescale 1ns/1ps
module host_bus_model (
   input wire logic aclk,
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic [1:0] bresp,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   output logic awvalid,
   output logic [7:0] awaddr,
   output logic wvalid,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic bready,
   output logic arvalid,
   output logic [7:0] araddr,
   output logic rready,
   output logic hang
);
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, hang} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
   end

   // Handshakes are judged from values held since the falling edge, so the
   // launching edge's own updates never race the decision
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      int n;
      logic ta, tw, tb;
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {24'h00_0000, d};
      wstrb <= 4'hf;
      bready <= 1'b1;
      for (n = 0; n < 400; n++) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) break;
      end
      bready <= 1'b0;
      if (n == 400) hang = 1'b1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ta, tb;
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      for (n = 0; n < 400; n++) begin
         @(negedge aclk);
         ta = arvalid & arready;
         tb = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tb) break;
      end
      rready <= 1'b0;
      if (n == 400) hang = 1'b1;
   endtask
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the interrupt mask and status block
`timescale 1ns/1ps
`include "nfc_irq_consts.svh"
module tb_top;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, hang;
   logic [7:0] awaddr, araddr, err_evt;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, mp;
   logic [1:0] bresp, rresp;
   logic [2:0] awprot = 3'h0;
   logic [2:0] arprot = 3'h0;
   logic [5:0] tp;
   logic osc_en, osc_stable, rx_active, tx_active, fifo_near_full, fifo_near_empty;
   logic ca_start, ca_end, ext_field, field_on, irq;
   int failures = 0;
   int check_count = 0;
   logic [1:0] wr_resp;
   int n;

   nfc_irq_core i_nfc_irq_core (.*, .rx_start(mp[3]), .rx_end(mp[2]), .tx_end(mp[1]), .bit_col(mp[0]),
      .cmd_done(tp[5]), .nrt_expire(tp[4]), .gpt_expire(tp[3]), .field_rise(tp[2]), .field_fall(tp[1]),
      .bitrate_found(tp[0]));
   host_bus_model u_host (.*);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic test_done();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask

   task automatic hung();
      if (hang) begin
         failures++;
         test_done();
      end
   endtask

   task automatic wrc(input logic [5:0] idx, input logic [7:0] d);
      logic [1:0] r;
      @(posedge aclk);
      u_host.wr({idx, 2'b00}, d, r);
      hung();
      chk({30'h0, r}, {30'h0, `RESP_OKAY});
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [7:0] x, input logic [1:0] xr);
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      u_host.rd({idx, 2'b00}, d, r);
      hung();
      chk(d, {24'h00_0000, x});
      chk({30'h0, r}, {30'h0, xr});
   endtask

   // One-cycle event pulses; returns settled, after irq has had time to follow
   task automatic pulse(input logic [3:0] m, input logic [5:0] t, input logic [7:0] e);
      @(posedge aclk);
      mp <= m;
      tp <= t;
      err_evt <= e;
      @(posedge aclk);
      mp <= '0;
      tp <= '0;
      err_evt <= '0;
      @(posedge aclk);
      @(negedge aclk);
   endtask

   initial begin
      aresetn = 1'b0;
      {osc_en, osc_stable, rx_active, tx_active, fifo_near_full, fifo_near_empty} = '0;
      {mp, tp, err_evt, ca_start, ca_end, ext_field} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdc(`IDX_MASK_MAIN, 8'h00, `RESP_OKAY);
      rdc(`IDX_MASK_TIM, 8'h00, `RESP_OKAY);
      rdc(`IDX_MASK_ERR, 8'h00, `RESP_OKAY);
      rdc(6'h1f, 8'h00, `RESP_SLVERR);
      // An unmapped write must be refused without touching any register
      @(posedge aclk);
      u_host.wr({6'h1f, 2'b00}, 8'hff, wr_resp);
      hung();
      chk({30'h0, wr_resp}, {30'h0, `RESP_SLVERR});
      wrc(`IDX_MASK_MAIN, 8'hff);
      rdc(`IDX_MASK_MAIN, 8'hfc, `RESP_OKAY);
      wrc(`IDX_MASK_TIM, 8'hff);
      rdc(`IDX_MASK_TIM, 8'hff, `RESP_OKAY);
      wrc(`IDX_MASK_ERR, 8'hff);
      rdc(`IDX_MASK_ERR, 8'hff, `RESP_OKAY);
      pulse(4'hf, 6'h00, 8'h00);
      chk({31'h0, irq}, 32'h0);
      wrc(`IDX_COMMAND, 8'h01);
      rdc(`IDX_MASK_MAIN, 8'h00, `RESP_OKAY);
      rdc(`IDX_MASK_ERR, 8'h00, `RESP_OKAY);
      pulse(4'hf, 6'h00, 8'h00);
      chk({31'h0, irq}, 32'h1);
      rdc(`IDX_STAT_MAIN, 8'h3c, `RESP_OKAY);
      rdc(`IDX_STAT_MAIN, 8'h00, `RESP_OKAY);
      @(posedge aclk);
      {osc_en, osc_stable, rx_active, fifo_near_full} <= 4'hf;
      repeat (3) @(posedge aclk);
      rdc(`IDX_STAT_MAIN, 8'hc0, `RESP_OKAY);
      @(posedge aclk);
      rx_active <= 1'b0;
      @(posedge aclk);
      {tx_active, fifo_near_empty} <= 2'h3;
      repeat (3) @(posedge aclk);
      rdc(`IDX_STAT_MAIN, 8'h40, `RESP_OKAY);
      pulse(4'h0, 6'h3f, 8'h00);
      rdc(`IDX_STAT_MAIN, 8'h02, `RESP_OKAY);
      rdc(`IDX_STAT_MAIN, 8'h02, `RESP_OKAY);
      rdc(`IDX_STAT_TIM, 8'hf9, `RESP_OKAY);
      rdc(`IDX_STAT_TIM, 8'h00, `RESP_OKAY);
      rdc(`IDX_STAT_MAIN, 8'h00, `RESP_OKAY);
      pulse(4'h0, 6'h00, 8'h89);
      rdc(`IDX_STAT_MAIN, 8'h01, `RESP_OKAY);
      rdc(`IDX_STAT_ERR, 8'h89, `RESP_OKAY);
      rdc(`IDX_STAT_MAIN, 8'h00, `RESP_OKAY);
      wrc(`IDX_MASK_MAIN, 8'hfc);
      pulse(4'h8, 6'h00, 8'h00);
      chk({31'h0, irq}, 32'h0);
      rdc(`IDX_STAT_MAIN, 8'h20, `RESP_OKAY);
      @(posedge aclk);
      ca_start <= 1'b1;
      @(posedge aclk);
      ca_start <= 1'b0;
      ext_field <= 1'b1;
      repeat (3) @(posedge aclk);
      ext_field <= 1'b0;
      rdc(`IDX_STAT_TIM, 8'h04, `RESP_OKAY);
      chk({31'h0, field_on}, 32'h0);
      @(posedge aclk);
      ca_start <= 1'b1;
      @(posedge aclk);
      ca_start <= 1'b0;
      ca_end <= 1'b1;
      @(posedge aclk);
      ca_end <= 1'b0;
      repeat (2) @(negedge aclk);
      chk({31'h0, field_on}, 32'h1);
      // Counting starts one cycle after field on and irq trails the guard bit by one, so n is the guard time
      for (n = 0; n < 1200 && irq !== 1'b1; n++)
         @(negedge aclk);
      chk(n, `GUARD_TIME_NS / `CLK_PERIOD_NS);
      rdc(`IDX_STAT_TIM, 8'h02, `RESP_OKAY);
      test_done();
   end

   initial begin
      repeat (50000) @(posedge aclk);
      failures++;
      test_done();
   end
endmodule
